//--- rtl/fsv_security.sv
`timescale 1ns/100ps
`default_nettype none
module fsv_security (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// CPU bus
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	input  wire logic        cpu_vec_fetch,
	input  wire logic        cpu_code_secure,
	input  wire logic        cpu_bdm,
	output logic [7:0]       cpu_rdata,
	output logic             cpu_busy,
	// Memory array side
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_wr,
	output logic             mem_rd,
	input  wire logic [7:0]  mem_rdata,
	// Command logic
	input  wire logic        blank_check_erased,
	input  wire logic        blank_check_bdm,
	// Debug
	input  wire logic        background_mode_pin,
	input  wire logic        bdm_enter_req,
	input  wire logic        dbg_enable_req,
	output logic             dbg_module_enable,
	output logic             bdm_active_enter,
	// Status
	output logic             secure,
	output logic             redirect_active
);
	import fsv_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		fsv_state_t  state;
		logic [3:0]  step;
		logic [7:0]  working_option_reg;
		logic [7:0]  working_protection_reg;
		logic [7:0]  flash_config_reg;
		logic        bkgd_low_at_reset;
		logic        unlocked;
		logic [7:0]  rdata;
	} fsv_sec_t;

	fsv_sec_t st_r;
	fsv_sec_t st_nxt;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic fsv_is_secure_mem(input logic [15:0] a);
		fsv_is_secure_mem = (a >= FSV_FLASH_START)
			|| (a >= FSV_RAM_START && a <= FSV_RAM_END);
	endfunction : fsv_is_secure_mem

	function automatic logic fsv_is_key(input logic [15:0] a);
		fsv_is_key = a[15:3] == FSV_ADDR_KEY_BASE[15:3];
	endfunction : fsv_is_key

	function automatic logic fsv_is_hreg(input logic [15:0] a);
		fsv_is_hreg = a >= FSV_HREG_BASE
			&& a < FSV_HREG_BASE + {12'h000, FSV_HREG_COUNT};
	endfunction : fsv_is_hreg

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	logic [15:0] redir_addr;
	logic        key_match;
	logic        load_key_we;
	logic        key_entry_we;
	logic        key_close;

	fsv_vec_redirect u_redirect (
		.prot_reg        (st_r.working_protection_reg),
		.nored           (st_r.working_option_reg[FSV_OPT_NORED_BIT]),
		.vec_fetch       (cpu_vec_fetch),
		.addr_in         (cpu_addr),
		.addr_out        (redir_addr),
		.redirect_active (redirect_active)
	);

	fsv_key_cmp u_key (
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.load_we     (load_key_we),
		.load_idx    (st_r.step[2:0]),
		.load_data   (mem_rdata),
		.entry_we    (key_entry_we),
		.entry_idx   (cpu_addr[2:0]),
		.entry_data  (cpu_wdata),
		.entry_close (key_close),
		.key_match   (key_match)
	);

	// ------------------------------------------------------------
	// Access control
	// ------------------------------------------------------------
	logic       running;
	logic       trusted;
	logic       blocked;
	logic       key_access_control;
	logic       key_wr;
	logic       hreg_hit;
	logic [3:0] hreg_idx;
	logic [15:0] hreg_off;

	always_comb begin
		running  = st_r.state == FSV_ST_RUN;
		// Only secure code outside debug is trusted
		trusted  = cpu_code_secure && !cpu_bdm;
		// Registers and debug are never secure resources
		blocked  = secure && !trusted && fsv_is_secure_mem(cpu_addr);
		key_access_control   = st_r.flash_config_reg[FSV_CFG_KEY_ACCESS_CONTROL_BIT];
		key_wr   = running && cpu_wr && key_access_control && fsv_is_key(cpu_addr)
			&& trusted;
		hreg_hit = running && fsv_is_hreg(cpu_addr);
		hreg_off = cpu_addr - FSV_HREG_BASE;
		hreg_idx = hreg_off[3:0];
	end

	assign key_entry_we = key_wr;
	assign load_key_we  = st_r.state == FSV_ST_LOAD && st_r.step < FSV_KEY_BYTES;

	// ------------------------------------------------------------
	// Memory side
	// ------------------------------------------------------------
	always_comb begin
		mem_wdata = cpu_wdata;
		if (!running) begin
			// Reset load walks key bytes, then protection, then option
			if (st_r.step == FSV_LOAD_PROT_STEP) begin
				mem_addr = FSV_ADDR_NONVOLATILE_PROTECTION_BYTE;
			end else if (st_r.step == FSV_LOAD_OPT_STEP) begin
				mem_addr = FSV_ADDR_NONVOLATILE_OPTION_BYTE;
			end else begin
				mem_addr = FSV_ADDR_KEY_BASE + {12'h000, st_r.step};
			end
			mem_rd = 1'b1;
			mem_wr = 1'b0;
		end else begin
			mem_addr = redir_addr;
			mem_rd   = cpu_rd && !blocked && !hreg_hit;
			mem_wr   = cpu_wr && !blocked && !hreg_hit && !key_wr;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		key_close = 1'b0;
		case (st_r.state)
			FSV_ST_LOAD: begin
				if (st_r.step == 4'h0) begin
					st_nxt.bkgd_low_at_reset = !background_mode_pin;
				end
				if (st_r.step == FSV_LOAD_PROT_STEP) begin
					st_nxt.working_protection_reg = mem_rdata;
				end
				if (st_r.step == FSV_LOAD_OPT_STEP) begin
					st_nxt.working_option_reg = mem_rdata;
				end
				st_nxt.step = st_r.step + 4'h1;
				if (st_r.step == FSV_LOAD_STEPS - 4'h1) begin
					st_nxt.state = FSV_ST_RUN;
				end
			end
			FSV_ST_RUN: begin
				if (cpu_wr && hreg_hit) begin
					if (hreg_idx == FSV_IDX_CFG) begin
						// Key access only when backdoor enabled
						st_nxt.flash_config_reg = cpu_wdata & FSV_CFG_WRITE_MASK;
						if (!st_r.working_option_reg[FSV_OPT_BACKDOOR_KEY_ENABLE_BIT]) begin
							st_nxt.flash_config_reg[FSV_CFG_KEY_ACCESS_CONTROL_BIT] = 1'b0;
						end
						key_close = key_access_control && !cpu_wdata[FSV_CFG_KEY_ACCESS_CONTROL_BIT];
					end else if (hreg_idx == FSV_IDX_PROT && cpu_bdm) begin
						st_nxt.working_protection_reg = cpu_wdata;
					end
				end
				if ((key_match && st_r.working_option_reg[FSV_OPT_BACKDOOR_KEY_ENABLE_BIT])
					|| (blank_check_erased && blank_check_bdm)) begin
					st_nxt.working_option_reg[1:0] = FSV_SEC_OPEN;
					st_nxt.unlocked = 1'b1;
				end
			end
			default: begin
				st_nxt.state = FSV_ST_LOAD;
			end
		endcase
		// Read data, registered
		st_nxt.rdata = 8'h00;
		if (running && cpu_rd) begin
			if (hreg_hit) begin
				if (hreg_idx == FSV_IDX_OPT) begin
					st_nxt.rdata = st_r.working_option_reg & FSV_OPT_READ_MASK;
				end else if (hreg_idx == FSV_IDX_CFG) begin
					st_nxt.rdata = st_r.flash_config_reg;
				end else if (hreg_idx == FSV_IDX_PROT) begin
					st_nxt.rdata = st_r.working_protection_reg;
				end else begin
					st_nxt.rdata = 8'h00;
				end
			end else if (!blocked) begin
				st_nxt.rdata = mem_rdata;
			end else begin
				st_nxt.rdata = 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r.state                  <= FSV_ST_LOAD;
			st_r.step                   <= 4'h0;
			st_r.working_option_reg     <= FSV_OPT_RST;
			st_r.working_protection_reg <= FSV_PROT_RST;
			st_r.flash_config_reg       <= FSV_CFG_RST;
			st_r.bkgd_low_at_reset      <= 1'b0;
			st_r.unlocked               <= 1'b0;
			st_r.rdata                  <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		secure            = st_r.working_option_reg[1:0] != FSV_SEC_OPEN;
		dbg_module_enable = running && dbg_enable_req && !secure;
		bdm_active_enter  = running && (secure ? st_r.bkgd_low_at_reset
			: (bdm_enter_req || st_r.bkgd_low_at_reset));
		cpu_busy          = !running;
		cpu_rdata         = st_r.rdata;
	end

endmodule : fsv_security
`default_nettype wire

//--- rtl/fsv_pkg.sv
package fsv_pkg;

	// ------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------
	localparam logic [15:0] FSV_ADDR_NONVOLATILE_PROTECTION_BYTE     = 16'hFFBD;
	localparam logic [15:0] FSV_ADDR_NONVOLATILE_OPTION_BYTE      = 16'hFFBF;
	localparam logic [15:0] FSV_ADDR_KEY_BASE   = 16'hFFB0;
	localparam logic [15:0] FSV_VEC_LO          = 16'hFFC0;
	localparam logic [15:0] FSV_VEC_HI          = 16'hFFFD;
	localparam logic [15:0] FSV_FLASH_START     = 16'hC000;
	localparam logic [15:0] FSV_RAM_START       = 16'h0070;
	localparam logic [15:0] FSV_RAM_END         = 16'h046F;
	localparam logic [15:0] FSV_HREG_BASE       = 16'h1820;
	localparam logic [3:0]  FSV_HREG_COUNT      = 4'h9;

	// ------------------------------------------------------------
	// High-page register indices
	// ------------------------------------------------------------
	localparam logic [3:0]  FSV_IDX_OPT         = 4'h1;
	localparam logic [3:0]  FSV_IDX_CFG         = 4'h3;
	localparam logic [3:0]  FSV_IDX_PROT        = 4'h4;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          FSV_OPT_BACKDOOR_KEY_ENABLE_BIT   = 7;
	localparam int          FSV_OPT_NORED_BIT   = 6;
	localparam logic [7:0]  FSV_OPT_READ_MASK   = 8'hC3;
	localparam int          FSV_CFG_KEY_ACCESS_CONTROL_BIT  = 5;
	localparam logic [7:0]  FSV_CFG_WRITE_MASK  = 8'h20;
	localparam int          FSV_PROT_DIS_BIT    = 0;
	localparam logic [1:0]  FSV_SEC_OPEN        = 2'h2;
	localparam logic [8:0]  FSV_BLOCK_LOW_ONES  = 9'h1FF;
	localparam logic [6:0]  FSV_FPS_NONE        = 7'h7F;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0]  FSV_OPT_RST         = 8'hFF;
	localparam logic [7:0]  FSV_PROT_RST        = 8'hFF;
	localparam logic [7:0]  FSV_CFG_RST         = 8'h00;
	localparam logic [3:0]  FSV_KEY_BYTES       = 4'h8;
	localparam logic [3:0]  FSV_LOAD_STEPS      = 4'hA;
	localparam logic [3:0]  FSV_LOAD_PROT_STEP  = 4'h8;
	localparam logic [3:0]  FSV_LOAD_OPT_STEP   = 4'h9;

	typedef enum logic [1:0] {
		FSV_ST_LOAD = 2'b00,
		FSV_ST_RUN  = 2'b01
	} fsv_state_t;

endpackage : fsv_pkg

//--- rtl/fsv_key_cmp.sv
`timescale 1ns/100ps
`default_nettype none
module fsv_key_cmp (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Stored key load
	input  wire logic       load_we,
	input  wire logic [2:0] load_idx,
	input  wire logic [7:0] load_data,
	// Key entry
	input  wire logic       entry_we,
	input  wire logic [2:0] entry_idx,
	input  wire logic [7:0] entry_data,
	input  wire logic       entry_close,
	// Result
	output logic            key_match
);
	import fsv_pkg::*;

	typedef struct packed {
		logic [7:0][7:0] key;
		logic [3:0]      count;
		logic            bad;
		logic            match;
	} fsv_kc_t;

	fsv_kc_t st_r;
	fsv_kc_t st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.match = 1'b0;
		if (load_we) begin
			st_nxt.key[load_idx] = load_data;
		end
		// Ascending order, one byte per write
		if (entry_we) begin
			if ({1'b0, entry_idx} != st_r.count || entry_data != st_r.key[entry_idx]) begin
				st_nxt.bad = 1'b1;
			end
			st_nxt.count = st_r.count + 4'h1;
		end
		if (entry_close) begin
			st_nxt.match = !st_r.bad && st_r.count == FSV_KEY_BYTES;
			st_nxt.count = 4'h0;
			st_nxt.bad   = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign key_match = st_r.match;

endmodule : fsv_key_cmp
`default_nettype wire

//--- rtl/fsv_vec_redirect.sv
`timescale 1ns/100ps
`default_nettype none
module fsv_vec_redirect (
	// Configuration
	input  wire logic [7:0]  prot_reg,
	input  wire logic        nored,
	// Fetch
	input  wire logic        vec_fetch,
	input  wire logic [15:0] addr_in,
	// Result
	output logic [15:0]      addr_out,
	output logic             redirect_active
);
	import fsv_pkg::*;

	logic [15:0] last_open;
	logic        partial;

	always_comb begin
		last_open = {prot_reg[7:1], FSV_BLOCK_LOW_ONES};
		// Some but not all of the array protected
		partial   = !prot_reg[FSV_PROT_DIS_BIT] && prot_reg[7:1] != FSV_FPS_NONE
			&& last_open >= FSV_FLASH_START;
		redirect_active = !nored && partial;
		addr_out = addr_in;
		// Reset vector never moves
		if (redirect_active && vec_fetch && addr_in >= FSV_VEC_LO
			&& addr_in <= FSV_VEC_HI) begin
			addr_out = {prot_reg[7:1], addr_in[8:0]};
		end
	end

endmodule : fsv_vec_redirect
`default_nettype wire

//--- tb/fsv_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fsv_monitor (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// CPU bus
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_wr,
	input wire logic        cpu_rd,
	input wire logic        cpu_vec_fetch,
	input wire logic        cpu_code_secure,
	input wire logic        cpu_bdm,
	input wire logic [7:0]  cpu_rdata,
	input wire logic        cpu_busy,
	// Array side
	input wire logic [15:0] mem_addr,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	// Status
	input wire logic        blank_check_erased,
	input wire logic        blank_check_bdm,
	input wire logic        dbg_module_enable,
	input wire logic        secure,
	input wire logic        redirect_active
);
	// ------------------------------------------------------------
	// Access classes
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic sec_mem = cpu_addr >= 16'hc000 || (cpu_addr >= 16'h0070 && cpu_addr <= 16'h046f);
	wire logic own = cpu_code_secure && !cpu_bdm;
	wire logic plain_rd = cpu_rd && !cpu_vec_fetch && !cpu_busy;
	wire logic blocked = secure && !own && sec_mem;
	wire logic vec_rd = cpu_rd && cpu_vec_fetch && !cpu_busy;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_block_read: assert property (plain_rd && blocked |-> !mem_rd)
		else $error("blocked read reached array");
	a_block_zero: assert property (plain_rd && blocked |=> cpu_rdata == 8'h00)
		else $error("blocked read not zero");
	a_block_write: assert property (cpu_wr && !cpu_busy && blocked |-> !mem_wr)
		else $error("blocked write reached array");
	a_trusted_read: assert property (plain_rd && own && sec_mem |-> mem_rd && mem_addr == cpu_addr)
		else $error("trusted read not passed");
	a_reset_vector: assert property (vec_rd && cpu_addr >= 16'hfffe |-> mem_addr == cpu_addr)
		else $error("reset vector moved");
	a_redirect_low: assert property (vec_rd && redirect_active && cpu_addr inside {[16'hffc0:16'hfffd]}
		|-> mem_addr[8:0] == cpu_addr[8:0] && mem_addr[15:9] != 7'h7f)
		else $error("vector not redirected");
	a_debug_locked: assert property (secure |-> !dbg_module_enable)
		else $error("debug enabled while secure");
	a_load_seq: assert property ($fell(sys_rst) |-> secure ##1 mem_rd [*8] ##[1:3] !cpu_busy)
		else $error("reset load sequence wrong");
	a_blank_clear: assert property (blank_check_erased && blank_check_bdm && !cpu_busy |=> !secure)
		else $error("blank check kept security");
	c_unsecured: cover property (!secure);
	c_redirect: cover property (vec_rd && redirect_active);
	c_blocked: cover property (plain_rd && blocked);
endmodule : fsv_monitor

bind fsv_security fsv_monitor u_mon (.sys_clk, .sys_rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_vec_fetch,
	.cpu_code_secure, .cpu_bdm, .cpu_rdata, .cpu_busy, .mem_addr, .mem_wr, .mem_rd,
	.blank_check_erased, .blank_check_bdm, .dbg_module_enable, .secure, .redirect_active);
`default_nettype wire

//--- tb/fsv_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsv_flash_model (
	// Clock
	input wire logic        sys_clk,
	// Array port
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	output logic [7:0]      mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;
	initial begin
		last_r = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8);
		end
	end
	// Unselected array shows inverse of last byte
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
	always @(posedge sys_clk) begin
		if (mem_rd) begin
			last_r <= mem[mem_addr];
		end
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule : fsv_flash_model
`default_nettype wire

//--- tb/flash_security_vector_redirect_test.sv
`timescale 1ns/100ps
`default_nettype none
module flash_security_vector_redirect_test;
	logic        sys_clk, sys_rst, cpu_wr, cpu_rd, cpu_vec_fetch, cpu_code_secure, cpu_bdm;
	logic [15:0] cpu_addr, mem_addr;
	logic [7:0]  cpu_wdata, cpu_rdata, mem_wdata, mem_rdata;
	logic        cpu_busy, mem_wr, mem_rd, blank_check_erased, blank_check_bdm;
	logic        background_mode_pin, bdm_enter_req, dbg_enable_req;
	logic        dbg_module_enable, bdm_active_enter, secure, redirect_active, rd_seen;
	logic [7:0]  key [8];
	logic [7:0]  exp_q [$];
	int          bad_count, n_compared, cyc;
	integer      seed;
	fsv_security dut (.sys_clk, .sys_rst, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_vec_fetch,
		.cpu_code_secure, .cpu_bdm, .cpu_rdata, .cpu_busy, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
		.mem_rdata, .blank_check_erased, .blank_check_bdm, .background_mode_pin, .bdm_enter_req,
		.dbg_enable_req, .dbg_module_enable, .bdm_active_enter, .secure, .redirect_active);
	fsv_flash_model flash (.sys_clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction : pat
	task automatic give_verdict();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: flag %b not %b", $time, g, e);
		end
	endtask : chk1
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : chk16
	// Flags are write, read, vector, trusted code, debug
	task automatic req(input logic [15:0] a, input logic [7:0] d, input logic [4:0] f);
		@(posedge sys_clk);
		#1;
		cpu_addr = a;
		cpu_wdata = d;
		{cpu_wr, cpu_rd, cpu_vec_fetch, cpu_code_secure, cpu_bdm} = f;
		#10;
	endtask : req
	// Flags are vector, trusted, debug, array read expected
	task automatic rd(input logic [15:0] a, ea, input logic [3:0] f, input logic [7:0] e);
		req(a, 8'h00, {2'b01, f[3:1]});
		exp_q.push_back(e);
		if (a[15:4] != 12'h182) begin
			chk1(mem_rd, f[0]);
		end
		if (f[0]) begin
			chk16(mem_addr, ea);
		end
		req(16'h0000, 8'h00, 5'b00000);
	endtask : rd
	// Flags are trusted, debug, array write expected
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [2:0] f);
		req(a, d, {3'b100, f[2:1]});
		chk1(mem_wr, f[0]);
		req(16'h0000, 8'h00, 5'b00000);
	endtask : wr
	task automatic boot(input logic [7:0] opt, input logic [7:0] prot);
		flash.mem[16'hffbf] = opt;
		flash.mem[16'hffbd] = prot;
		@(posedge sys_clk);
		#1;
		sys_rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < 20 && cpu_busy !== 1'b0; i++) @(posedge sys_clk);
	endtask : boot
	// Last flag: key writes expected to reach the array
	task automatic unlock(input logic [7:0] flip, input logic b, input logic e);
		wr(16'h1823, 8'h20, 3'b100);
		for (int i = 0; i < 8; i++) begin
			wr(16'hffb0 + 16'(i), key[i] ^ (i == 7 ? flip : 8'h00), {1'b1, b, e});
		end
		wr(16'h1823, 8'h00, 3'b100);
		repeat (3) @(posedge sys_clk);
		#10;
	endtask : unlock
	task automatic blank(input logic b);
		@(posedge sys_clk);
		#1;
		blank_check_erased = 1'b1;
		blank_check_bdm = b;
		@(posedge sys_clk);
		#1;
		blank_check_erased = 1'b0;
		#10;
	endtask : blank
	// ------------------------------------------------------------
	// Clock, watcher, timeout
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (rd_seen) begin
			chk16({8'h00, cpu_rdata}, {8'h00, exp_q.pop_front()});
		end
		rd_seen <= cpu_rd & ~cpu_busy;
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{cpu_addr, cpu_wdata, cpu_wr, cpu_rd, cpu_vec_fetch, cpu_code_secure, cpu_bdm} = '0;
		{blank_check_erased, blank_check_bdm, rd_seen} = '0;
		{sys_rst, background_mode_pin, bdm_enter_req, dbg_enable_req} = '1;
		seed = 32'ha245;
		for (int i = 0; i < 8; i++) begin
			key[i] = 8'($random(seed));
			flash.mem[16'hffb0 + i] = key[i];
		end
		boot(8'hff, 8'hfc);
		chk1(secure, 1'b1);
		chk1(redirect_active, 1'b0);
		chk1(dbg_module_enable, 1'b0);
		chk1(bdm_active_enter, 1'b0);
		rd(16'hc123, 16'hc123, 4'b0000, 8'h00);
		rd(16'h0100, 16'h0100, 4'b0010, 8'h00);
		rd(16'h0100, 16'h0100, 4'b0101, pat(16'h0100));
		rd(16'h1824, 16'h1824, 4'b0000, 8'hfc);
		wr(16'h1824, 8'hf8, 3'b100);
		rd(16'h1824, 16'h1824, 4'b0010, 8'hfc);
		wr(16'h1824, 8'hf8, 3'b010);
		rd(16'h1824, 16'h1824, 4'b0000, 8'hf8);
		boot(8'hbf, 8'hfc);
		rd(16'h1821, 16'h1821, 4'b0000, 8'h83);
		chk1(redirect_active, 1'b1);
		rd(16'hffc4, 16'hfdc4, 4'b1101, pat(16'hfdc4));
		rd(16'hfffe, 16'hfffe, 4'b1101, pat(16'hfffe));
		unlock(8'h01, 1'b0, 1'b0);
		chk1(secure, 1'b1);
		unlock(8'h00, 1'b1, 1'b0);
		chk1(secure, 1'b1);
		unlock(8'h00, 1'b0, 1'b0);
		chk1(secure, 1'b0);
		chk1(dbg_module_enable, 1'b1);
		rd(16'h1821, 16'h1821, 4'b0000, 8'h82);
		rd(16'hc123, 16'hc123, 4'b0001, pat(16'hc123));
		boot(8'h3f, 8'h00);
		chk1(redirect_active, 1'b0);
		wr(16'h1823, 8'h20, 3'b100);
		rd(16'h1823, 16'h1823, 4'b0000, 8'h00);
		// Key access off: key writes act as array writes
		unlock(8'h00, 1'b0, 1'b1);
		chk1(secure, 1'b1);
		blank(1'b0);
		chk1(secure, 1'b1);
		blank(1'b1);
		chk1(secure, 1'b0);
		background_mode_pin = 1'b0;
		boot(8'hff, 8'hff);
		chk1(bdm_active_enter, 1'b1);
		// Option byte programmed to 1:0 stays open after reset
		background_mode_pin = 1'b1;
		boot(8'hfe, 8'hff);
		chk1(secure, 1'b0);
		repeat (3) @(posedge sys_clk);
		give_verdict();
	end
endmodule : flash_security_vector_redirect_test
`default_nettype wire
